// *** core/sfbfe_front_end.sv ***
// Serial flash bus front end: pin sampling, select qualification, pause, width switching, address map
// ************************************************************
// Notes on behaviour
// - Works with host clock mode 0 or 3
// - Sample on rising edge, drive after falling
// - Two-line transfers only for three dual opcodes
// - Dual opcodes turn lines zero, one bidirectional
// - Four-line transfers for five quad opcodes
// - Quad opcodes add lines two and three
// - Quad opcodes need quad enable bit set
// - Select needs high then falling edge first
// - Ignore all instructions while power reset held
// - Reset release brings all state to defaults
// - Reset reassertion stops responding at once
// - Select low means selected and active
// - Standby on deselect only without write cycle
// - Pause keeps the current bit position
// - Paused: outputs off, input and clock ignored
// - Select high while paused aborts the sequence
// - Pause starts with pause low, clock low
// - Pause ends with pause high, clock low
// - 1024 sectors of 4 KB
// - 64 blocks of 64 KB
// - 128 half blocks of 32 KB
// - Deselected: inputs ignored, outputs high impedance
// - Quad enable disables pause, line three data
// - Quad enable bit sits at bit one
// ************************************************************
`timescale 1ns/10ps

module sfbfe_front_end
  import sfbfe_pkg::*;
#(
  parameter int ADDR_BYTES = 3  // Address bytes after an addressed opcode
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clkEn,
  input wire sfbfe_pin_in_t pinsIn,
  input wire logic quadEnableBit,
  input wire logic writeInProgress,
  input wire logic [7:0] txByte,
  output sfbfe_pin_out_t pinsOut,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic rxFirst,
  output logic txTaken,
  output sfbfe_addr_map_t addrMap,
  output logic addrValid,
  output logic activeMode,
  output logic holdActive,
  output logic busMode3
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ADDR_BYTES < 3 || ADDR_BYTES > 4) begin : g_bad_addr
    $error("ADDR_BYTES must be 3 or 4");
  end

  localparam int ASH_W = 8 * ADDR_BYTES;
  localparam logic [1:0] ADDR_LAST = 2'(ADDR_BYTES - 1);

  // ************************************************************
  // Pin synchronisers, three stages each
  // ************************************************************
  logic [2:0] csSync_q;    // Chip select stages
  logic [2:0] sclkSync_q;  // Serial clock stages
  logic [3:0] lineS3;      // Third stage of each data line
  logic [3:0] lineAgree;   // Second and third stage agree

  // Select and clock share one process; both are plain pin samples
  always_ff @(posedge clock) begin
    if (rst) begin
      csSync_q <= 3'h0;
      sclkSync_q <= 3'h0;
    end else if (clkEn) begin
      csSync_q <= {csSync_q[1:0], pinsIn.csN};
      sclkSync_q <= {sclkSync_q[1:0], pinsIn.sclk};
    end
  end

  // One synchroniser per data line
  for (genvar i = 0; i < 4; i++) begin : g_line_sync
    logic [2:0] lineSync_q;
    always_ff @(posedge clock) begin
      if (rst) begin
        lineSync_q <= 3'h0;
      end else if (clkEn) begin
        lineSync_q <= {lineSync_q[1:0], pinsIn.data[i]};
      end
    end
    assign lineS3[i] = lineSync_q[2];
    assign lineAgree[i] = lineSync_q[1] == lineSync_q[2];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic csLevel_q;            // Filtered chip select level
  logic sclkLevel_q;          // Filtered serial clock level
  logic holdLevel_q;          // Filtered pause pin level
  logic armed_q;              // Select has been seen high since reset
  logic holdActive_q;         // Pause condition in force
  sfbfe_state_t st_q;         // Bus sequence state
  logic [2:0] width_q;        // Bits per edge in the current phase
  logic [2:0] dataW_q;        // Width planned for the data phase
  logic readOut_q;            // Data phase drives the lines
  logic [2:0] bitCnt_q;       // Bit position within the byte
  logic [1:0] addrCnt_q;      // Address bytes taken
  logic [7:0] rxShift_q;      // Incoming bits
  logic [ASH_W-1:0] addrShift_q;  // Address bytes so far
  logic [7:0] txShift_q;      // Outgoing bits not yet driven
  logic txStarted_q;          // First outgoing bits are on the lines

  // ************************************************************
  // Edge finding and qualification
  // ************************************************************
  wire csAgree = csSync_q[1] == csSync_q[2];
  wire sclkAgree = sclkSync_q[1] == sclkSync_q[2];
  wire sclkRise = sclkAgree & sclkSync_q[2] & ~sclkLevel_q;
  wire sclkFall = sclkAgree & ~sclkSync_q[2] & sclkLevel_q;
  wire csFallEv = armed_q & csLevel_q & csAgree & ~csSync_q[2];
  wire selected = armed_q & ~csLevel_q;
  wire engRise = selected & ~holdActive_q & sclkRise;
  wire engFall = selected & ~holdActive_q & sclkFall;
  wire [3:0] bitSum = {1'b0, bitCnt_q} + {1'b0, width_q};
  wire byteDone = bitSum == BYTE_BITS;
  wire [2:0] bitCntNext = byteDone ? BIT_CNT_RST : bitSum[2:0];

  // Incoming bits: line zero alone, lines one-zero, or all four
  wire [7:0] rxNext = (width_q == WIDTH_4) ? {rxShift_q[3:0], lineS3} :
                      (width_q == WIDTH_2) ? {rxShift_q[5:0], lineS3[1:0]} :
                      {rxShift_q[6:0], lineS3[0]};
  wire sfbfe_cmd_t cmdInfo = sfbfe_decode(rxNext);
  wire quadRefused = cmdInfo.quad & ~quadEnableBit;
  wire [ASH_W-1:0] addrNext = {addrShift_q[ASH_W-9:0], rxNext};
  wire [ADDR_W-1:0] addrFull = addrNext[ADDR_W-1:0];

  // Outgoing bits: a fresh byte is taken at the first edge of each byte
  wire [7:0] txSrc = (bitCnt_q == BIT_CNT_RST) ? txByte : txShift_q;
  wire [3:0] txBits = (width_q == WIDTH_4) ? txSrc[7:4] :
                      (width_q == WIDTH_2) ? {2'b00, txSrc[7:6]} :
                      {2'b00, txSrc[7], 1'b0};  // One line answers on line one
  wire [7:0] txShiftNext = (width_q == WIDTH_4) ? {txSrc[3:0], 4'h0} :
                           (width_q == WIDTH_2) ? {txSrc[5:0], 2'h0} :
                           {txSrc[6:0], 1'h0};
  wire [3:0] oeMask = (width_q == WIDTH_4) ? OE_MASK_W4 :
                      (width_q == WIDTH_2) ? OE_MASK_W2 : OE_MASK_W1;
  wire driving = (st_q == ST_DOUT) & txStarted_q & selected & ~holdActive_q;
  wire [3:0] oeNext = driving ? oeMask : OE_ALL_OFF;

  // Pause is honoured only while selected with quad enable clear and then moves only with the clock low; otherwise it clears at once
  wire holdAllowed = selected & ~quadEnableBit;
  wire holdNext = ~holdAllowed ? 1'b0 :
                  (~sclkLevel_q ? ~holdLevel_q : holdActive_q);

  // ************************************************************
  // Select, clock and pause levels
  // ************************************************************
  // Levels settle to zero under reset so that a select held low never arms
  always_ff @(posedge clock) begin
    if (rst) begin
      csLevel_q <= 1'b0;
      sclkLevel_q <= 1'b0;
      holdLevel_q <= 1'b0;
      armed_q <= 1'b0;
      holdActive_q <= 1'b0;
    end else if (clkEn) begin
      csLevel_q <= csAgree ? csSync_q[2] : csLevel_q;
      sclkLevel_q <= sclkAgree ? sclkSync_q[2] : sclkLevel_q;
      holdLevel_q <= lineAgree[3] ? lineS3[3] : holdLevel_q;
      armed_q <= armed_q | csLevel_q;
      holdActive_q <= holdNext;
    end
  end

  // ************************************************************
  // Bus sequence
  // ************************************************************
  // Deselection clears the frame; while paused no edge advances it
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= ST_IDLE;
      width_q <= WIDTH_1;
      dataW_q <= WIDTH_1;
      readOut_q <= 1'b0;
      bitCnt_q <= BIT_CNT_RST;
      addrCnt_q <= 2'h0;
      txStarted_q <= 1'b0;
    end else if (clkEn) begin
      if (!selected) begin
        // Frame over or aborted, also from the pause
        st_q <= ST_IDLE;
        width_q <= WIDTH_1;
        bitCnt_q <= BIT_CNT_RST;
        addrCnt_q <= 2'h0;
        txStarted_q <= 1'b0;
      end else if (st_q == ST_IDLE) begin
        st_q <= ST_OPCODE;
      end else if (engRise && st_q != ST_DOUT && st_q != ST_SKIP) begin
        bitCnt_q <= bitCntNext;
        if (byteDone) begin
          case (st_q)
            ST_OPCODE: begin
              if (quadRefused) begin
                st_q <= ST_SKIP;
              end else if (cmdInfo.hasAddr) begin
                st_q <= ST_ADDR;
                width_q <= cmdInfo.addrWidth;
                dataW_q <= cmdInfo.dataWidth;
                readOut_q <= cmdInfo.readOut;
              end else begin
                st_q <= ST_DIN;
              end
            end
            ST_ADDR: begin
              addrCnt_q <= addrCnt_q + 2'h1;
              if (addrCnt_q == ADDR_LAST) begin
                st_q <= readOut_q ? ST_DOUT : ST_DIN;
                width_q <= dataW_q;
                addrCnt_q <= 2'h0;
              end
            end
            default: begin
              st_q <= st_q;  // Data in keeps streaming
            end
          endcase
        end
      end else if (engFall && st_q == ST_DOUT) begin
        txStarted_q <= 1'b1;
        bitCnt_q <= bitCntNext;
      end
    end
  end

  // ************************************************************
  // Shift registers
  // ************************************************************
  // Stale bits simply fall off the top, so no clear is needed per byte
  always_ff @(posedge clock) begin
    if (rst) begin
      rxShift_q <= 8'h00;
      addrShift_q <= '0;
      txShift_q <= 8'h00;
    end else if (clkEn) begin
      if (engRise && (st_q == ST_OPCODE || st_q == ST_ADDR || st_q == ST_DIN)) begin
        rxShift_q <= rxNext;
      end
      if (engRise && st_q == ST_ADDR && byteDone) begin
        addrShift_q <= addrNext;
      end
      if (engFall && st_q == ST_DOUT) begin
        txShift_q <= txShiftNext;
      end
    end
  end

  // ************************************************************
  // User side outputs
  // ************************************************************
  // Strobes are one cycle wide; data holds until the next strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rxByte <= 8'h00;
      rxValid <= 1'b0;
      rxFirst <= 1'b0;
      txTaken <= 1'b0;
      addrMap <= '0;
      addrValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= engRise & byteDone & (st_q == ST_OPCODE || st_q == ST_DIN);
      rxFirst <= engRise & byteDone & (st_q == ST_OPCODE);
      txTaken <= engFall & (st_q == ST_DOUT) & (bitCnt_q == BIT_CNT_RST);
      addrValid <= engRise & byteDone & (st_q == ST_ADDR) & (addrCnt_q == ADDR_LAST);
      if (engRise && byteDone && (st_q == ST_OPCODE || st_q == ST_DIN)) begin
        rxByte <= rxNext;
      end
      if (engRise && byteDone && st_q == ST_ADDR && addrCnt_q == ADDR_LAST) begin
        addrMap.byteAddr <= addrFull;
        addrMap.sector <= addrFull[ARRAY_MSB:SECTOR_LSB];
        addrMap.halfBlock <= addrFull[ARRAY_MSB:HALF_LSB];
        addrMap.block <= addrFull[ARRAY_MSB:BLOCK_LSB];
      end
    end
  end

  // ************************************************************
  // Pins, power mode and status outputs
  // ************************************************************
  // Data changes only on a falling edge; enables follow the state each cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      pinsOut <= '{4'h0, OE_ALL_OFF};
      activeMode <= 1'b0;
      busMode3 <= 1'b0;
    end else if (clkEn) begin
      pinsOut.dataOeN <= oeNext;
      if (engFall && st_q == ST_DOUT) begin
        pinsOut.data <= txBits;
      end
      activeMode <= ~csLevel_q | writeInProgress;
      if (csFallEv) begin
        busMode3 <= sclkLevel_q;
      end
    end
  end

  assign holdActive = holdActive_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_dual_opcode;
    clkEn && engRise && st_q == ST_OPCODE && byteDone && rxNext == OP_DUAL_IO;
  endsequence
  sequence s_quad_refused;
    clkEn && engRise && st_q == ST_OPCODE && byteDone && quadRefused;
  endsequence

  a_dual_width_switch: assert property (s_dual_opcode |=> st_q == ST_ADDR && width_q == WIDTH_2)
    else $error("dual opcode did not switch to two lines");
  a_quad_needs_enable: assert property (s_quad_refused |=> st_q == ST_SKIP)
    else $error("quad opcode ran without quad enable");
  a_hold_lines_off: assert property (clkEn && holdActive_q |=> pinsOut.dataOeN == OE_ALL_OFF)
    else $error("line driven while paused");
  a_deselect_lines_off: assert property (clkEn && csLevel_q |=> pinsOut.dataOeN == OE_ALL_OFF)
    else $error("line driven while deselected");
  a_powerup_no_select: assert property (!armed_q |-> st_q == ST_IDLE)
    else $error("sequence started before select was seen high");
  a_hold_clock_low: assert property (holdActive_q != $past(holdActive_q) |->
      !$past(sclkLevel_q) || !$past(holdAllowed))
    else $error("pause changed with clock high");
  a_hold_keeps_bit: assert property (clkEn && holdActive_q && selected |=> $stable(bitCnt_q))
    else $error("bit position moved while paused");
  a_hold_abort_cs: assert property (clkEn && holdActive_q && csLevel_q |=> st_q == ST_IDLE && !holdActive_q)
    else $error("deselect during pause did not abort");
  a_standby_idle: assert property (clkEn && csLevel_q && !writeInProgress |=> !activeMode)
    else $error("not in standby after deselect");
  a_sector_block_map: assert property (addrValid |->
      addrMap.halfBlock[ARRAY_MSB-HALF_LSB:1] == addrMap.block &&
      addrMap.sector[ARRAY_MSB-SECTOR_LSB:3] == addrMap.halfBlock)
    else $error("address map fields disagree");
  a_por_ignores: assert property (disable iff (1'b0) rst |=> st_q == ST_IDLE && !armed_q)
    else $error("sequence state alive under power reset");

endmodule : sfbfe_front_end

// *** core/sfbfe_pkg.sv ***
// Shared constants, carrier structs and command decoding for the serial flash bus front end
package sfbfe_pkg;

  // ************************************************************
  // Instruction codes that change the transfer width
  // ************************************************************
  localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;  // Two-line data out, one-line address
  localparam logic [7:0] OP_DUAL_IO   = 8'hBB;  // Two-line address and data out
  localparam logic [7:0] OP_DUAL_ID   = 8'h92;  // Two-line identification read
  localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;  // Four-line data out, one-line address
  localparam logic [7:0] OP_QUAD_IO   = 8'hEB;  // Four-line address and data out
  localparam logic [7:0] OP_QUAD_WORD = 8'hE7;  // Four-line word read
  localparam logic [7:0] OP_QUAD_ID   = 8'h94;  // Four-line identification read
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;  // Four-line page program, data in

  // ************************************************************
  // Transfer widths in bits per serial clock edge
  // ************************************************************
  localparam logic [2:0] WIDTH_1 = 3'h1;
  localparam logic [2:0] WIDTH_2 = 3'h2;
  localparam logic [2:0] WIDTH_4 = 3'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;

  // Output enables, active low: a zero bit drives that data line
  localparam logic [3:0] OE_ALL_OFF = 4'hF;
  localparam logic [3:0] OE_MASK_W1 = 4'hD;  // Only data line one drives
  localparam logic [3:0] OE_MASK_W2 = 4'hC;  // Data lines zero and one
  localparam logic [3:0] OE_MASK_W4 = 4'h0;  // All four data lines

  // ************************************************************
  // Array address map: 4-KB sectors, 32-KB half blocks, 64-KB blocks
  // ************************************************************
  localparam int ADDR_W = 24;
  localparam int SECTOR_LSB = 12;
  localparam int HALF_LSB = 15;
  localparam int BLOCK_LSB = 16;
  localparam int ARRAY_MSB = 21;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic csN;         // Chip select, active low
    logic sclk;        // Serial clock from the host
    logic [3:0] data;  // Data lines three down to zero
  } sfbfe_pin_in_t;

  typedef struct packed {
    logic [3:0] data;     // Values driven on the data lines
    logic [3:0] dataOeN;  // Output enables, low while driving
  } sfbfe_pin_out_t;

  typedef struct packed {
    logic [ADDR_W-1:0] byteAddr;
    logic [ARRAY_MSB-SECTOR_LSB:0] sector;
    logic [ARRAY_MSB-HALF_LSB:0] halfBlock;
    logic [ARRAY_MSB-BLOCK_LSB:0] block;
  } sfbfe_addr_map_t;

  typedef struct packed {
    logic hasAddr;           // An address phase follows the opcode
    logic [2:0] addrWidth;   // Width of the address phase
    logic [2:0] dataWidth;   // Width of the data phase
    logic readOut;           // Data phase drives the lines
    logic quad;              // Needs the quad enable bit
  } sfbfe_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b00_0001,
    ST_OPCODE = 6'b00_0010,
    ST_ADDR   = 6'b00_0100,
    ST_DIN    = 6'b00_1000,
    ST_DOUT   = 6'b01_0000,
    ST_SKIP   = 6'b10_0000
  } sfbfe_state_t;

  // Width plan of one opcode; anything unlisted streams in on one line
  function automatic sfbfe_cmd_t sfbfe_decode(input logic [7:0] op);
    sfbfe_cmd_t c;
    c = '{1'b0, WIDTH_1, WIDTH_1, 1'b0, 1'b0};
    case (op)
      OP_DUAL_OUT: c = '{1'b1, WIDTH_1, WIDTH_2, 1'b1, 1'b0};
      OP_DUAL_IO, OP_DUAL_ID: c = '{1'b1, WIDTH_2, WIDTH_2, 1'b1, 1'b0};
      OP_QUAD_OUT: c = '{1'b1, WIDTH_1, WIDTH_4, 1'b1, 1'b1};
      OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_ID: c = '{1'b1, WIDTH_4, WIDTH_4, 1'b1, 1'b1};
      OP_QUAD_PROG: c = '{1'b1, WIDTH_1, WIDTH_4, 1'b0, 1'b1};
      default: c = '{1'b0, WIDTH_1, WIDTH_1, 1'b0, 1'b0};
    endcase
    return c;
  endfunction : sfbfe_decode

endpackage : sfbfe_pkg

// *** verification/sfbfe_host.sv ***
// Host serial bus controller model that drives the flash front end pins
`timescale 1ns/10ps

module sfbfe_host
  import sfbfe_pkg::*;
(
  input wire logic clock,
  input wire sfbfe_pin_out_t devOut,
  output sfbfe_pin_in_t pins
);
  // ************************************************************
  // Pin state
  // ************************************************************
  logic csN = 1'b0;  // Low from power-up on purpose, to probe arming
  logic sclk = 1'b0;  // Serial clock, still outside frames
  logic [3:0] hostData = 4'hF;  // Values the host puts on the lines
  logic [3:0] hostOeN = 4'hF;  // Low while the host drives a line
  logic [3:0] seen;  // Line levels caught at the last rise
  logic [3:0] wireLvl;  // Resolved line levels

  // Lines two, three pull up; zero, one float to the inverse of the last value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wireLvl[i] = !devOut.dataOeN[i] ? devOut.data[i] : !hostOeN[i] ? hostData[i] : (i > 1) ? 1'b1 : ~hostData[i];
    end
  end
  assign pins = '{csN, sclk, wireLvl};

  // Waits a number of falling system clock edges
  task automatic waitn(input int n);
    repeat (n) @(negedge clock);
  endtask : waitn

  // One serial clock: 65 ns low, 60 ns high, the device samples at the rise
  task automatic cyc(input logic [3:0] v);
    hostData = v;
    waitn(13);
    sclk = 1'b1;
    seen = wireLvl;
    waitn(12);
    sclk = 1'b0;
  endtask : cyc

  // Top n bits of b on line zero, lines one to three released
  task automatic send(input logic [7:0] b, input int n);
    hostOeN = 4'hE;
    for (int i = 7; i > 7 - n; i--) begin
      cyc({3'b111, b[i]});
    end
  endtask : send

  // One byte on two or four lines, highest bits first; unused lines released
  task automatic sendw(input logic [7:0] b, input int w);
    hostOeN = (w == 4) ? 4'h0 : 4'hC;
    for (int i = 8 - w; i >= 0; i -= w) begin
      cyc(4'(b >> i) | hostOeN);
    end
  endtask : sendw

  // Read clock with every line released
  task automatic rd();
    hostOeN = 4'hF;
    cyc(4'hF);
  endtask : rd

  // Select with the given idle clock level, then leave the clock low
  task automatic sel(input logic idle);
    sclk = idle;
    waitn(4);
    csN = 1'b0;
    waitn(6);
    sclk = 1'b0;
    waitn(4);
  endtask : sel

  // Deselect and release every line
  task automatic desel();
    csN = 1'b1;
    hostOeN = 4'hF;
    waitn(8);
  endtask : desel

  // Drive the pause line while the clock is low and select is held
  task automatic pause(input logic on);
    hostOeN[3] = 1'b0;
    hostData[3] = !on;
    waitn(8);
  endtask : pause
endmodule : sfbfe_host

// *** verification/serial_flash_bus_front_end_bench.sv ***
// Self-checking bench of the serial flash bus front end
`timescale 1ns/10ps

module serial_flash_bus_front_end_bench import sfbfe_pkg::*;;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  logic clock, rst, qeBit, wip, clkEn, txTaken;
  logic [7:0] txByte;
  sfbfe_pin_in_t pinsIn;
  sfbfe_pin_out_t pinsOut;
  logic [7:0] rxByte, lastRx;
  logic rxValid, rxFirst, addrValid, activeMode, holdActive, busMode3, lastFirst;
  sfbfe_addr_map_t addrMap, lastMap;
  int rxCnt = 0, addrCnt = 0, txCnt = 0, cycles = 0, errorCnt = 0, numChecks = 0, n;

  sfbfe_front_end u_sfbfe_front_end (.clock(clock), .rst(rst), .clkEn(clkEn), .pinsIn(pinsIn),
    .quadEnableBit(qeBit), .writeInProgress(wip), .txByte(txByte), .pinsOut(pinsOut), .rxByte(rxByte),
    .rxValid(rxValid), .rxFirst(rxFirst), .txTaken(txTaken), .addrMap(addrMap), .addrValid(addrValid),
    .activeMode(activeMode), .holdActive(holdActive), .busMode3(busMode3));
  sfbfe_host u_sfbfe_host (.clock(clock), .devOut(pinsOut), .pins(pinsIn));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Counts strobes, keeps the last byte and map, cuts a hang short
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rxValid) begin
      rxCnt <= rxCnt + 1;
      lastRx <= rxByte;
      lastFirst <= rxFirst;
    end
    if (addrValid) begin
      addrCnt <= addrCnt + 1;
      lastMap <= addrMap;
    end
    if (txTaken) begin
      txCnt <= txCnt + 1;
    end
    if (cycles == 20000) begin
      errorCnt++;
      reportAndStop();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [46:0] exp, input logic [46:0] got);
    numChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Select, opcode, then address 3E8123 on one line
  task automatic op_addr(input logic [7:0] op);
    u_sfbfe_host.sel(1'b0);
    u_sfbfe_host.send(op, 8);
    u_sfbfe_host.send(8'h3E, 8);
    u_sfbfe_host.send(8'h81, 8);
    u_sfbfe_host.send(8'h23, 8);
  endtask : op_addr

  task automatic reportAndStop();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : reportAndStop

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_armed();
    n = rxCnt;
    u_sfbfe_host.send(OP_DUAL_OUT, 8);
    chk("rx before arm", n, rxCnt);
    u_sfbfe_host.desel();
  endtask : t_armed

  task automatic t_dual();
    op_addr(OP_DUAL_OUT);
    chk("active", 1, activeMode);
    chk("mode", 0, busMode3);
    chk("opcode", 9'h13B, {lastFirst, lastRx});
    chk("map", {24'h3E_8123, 10'h3E8, 7'h7D, 6'h3E}, lastMap);
    u_sfbfe_host.rd();
    chk("dual oe", OE_MASK_W2, pinsOut.dataOeN);
    chk("dual bits", 2'h2, u_sfbfe_host.seen[1:0]);
    u_sfbfe_host.desel();
    chk("idle oe", OE_ALL_OFF, pinsOut.dataOeN);
  endtask : t_dual

  task automatic t_quad();
    n = addrCnt;
    op_addr(OP_QUAD_OUT);
    chk("quad refused", n, addrCnt);
    u_sfbfe_host.desel();
    qeBit = 1'b1;
    u_sfbfe_host.sel(1'b0);
    u_sfbfe_host.pause(1'b1);
    chk("pause off", 0, holdActive);
    u_sfbfe_host.pause(1'b0);
    u_sfbfe_host.desel();
    op_addr(OP_QUAD_OUT);
    u_sfbfe_host.rd();
    chk("quad oe", OE_MASK_W4, pinsOut.dataOeN);
    chk("quad bits", 4'hA, u_sfbfe_host.seen);
    u_sfbfe_host.desel();
    qeBit = 1'b0;
  endtask : t_quad

  // Two-line address in, then four-line data in with a frozen stretch
  task automatic t_wide();
    txByte = 8'h5C;
    u_sfbfe_host.sel(1'b0);
    u_sfbfe_host.send(OP_DUAL_IO, 8);
    u_sfbfe_host.sendw(8'h01, 2);
    u_sfbfe_host.sendw(8'hF0, 2);
    u_sfbfe_host.sendw(8'h00, 2);
    chk("dual io map", {24'h01_F000, 10'h01F, 7'h03, 6'h01}, lastMap);
    n = txCnt;
    u_sfbfe_host.rd();
    chk("dual io bits", 2'h1, u_sfbfe_host.seen[1:0]);
    chk("tx taken", n + 1, txCnt);
    u_sfbfe_host.desel();
    qeBit = 1'b1;
    op_addr(OP_QUAD_PROG);
    u_sfbfe_host.sendw(8'h96, 4);
    chk("quad in", 9'h096, {lastFirst, lastRx});
    chk("quad in oe", OE_ALL_OFF, pinsOut.dataOeN);
    n = rxCnt;
    clkEn = 1'b0;
    u_sfbfe_host.sendw(8'hFF, 4);
    clkEn = 1'b1;
    u_sfbfe_host.waitn(6);
    chk("frozen", n, rxCnt);
    u_sfbfe_host.sendw(8'h3C, 4);
    chk("after freeze", 8'h3C, lastRx);
    u_sfbfe_host.desel();
    qeBit = 1'b0;
  endtask : t_wide

  task automatic t_pause();
    u_sfbfe_host.sel(1'b0);
    u_sfbfe_host.send(8'h05, 8);
    u_sfbfe_host.send(8'hC3, 4);
    u_sfbfe_host.pause(1'b1);
    chk("hold on", 1, holdActive);
    u_sfbfe_host.cyc(4'h0);
    u_sfbfe_host.cyc(4'h1);
    chk("hold oe", OE_ALL_OFF, pinsOut.dataOeN);
    u_sfbfe_host.pause(1'b0);
    chk("hold off", 0, holdActive);
    u_sfbfe_host.send(8'h30, 4);
    chk("resume", 8'hC3, lastRx);
    u_sfbfe_host.pause(1'b1);
    u_sfbfe_host.desel();
    chk("abort", 0, holdActive);
  endtask : t_pause

  task automatic t_power();
    wip = 1'b1;
    u_sfbfe_host.waitn(6);
    chk("busy active", 1, activeMode);
    wip = 1'b0;
    u_sfbfe_host.waitn(6);
    chk("standby", 0, activeMode);
    u_sfbfe_host.sel(1'b1);
    chk("mode3", 1, busMode3);
    n = rxCnt;
    u_sfbfe_host.send(8'h05, 8);
    chk("mode3 rx", n + 1, rxCnt);
    rst = 1'b1;
    n = rxCnt;
    u_sfbfe_host.send(OP_DUAL_OUT, 8);
    chk("rx in reset", n, rxCnt);
    chk("reset oe", OE_ALL_OFF, pinsOut.dataOeN);
    rst = 1'b0;
    u_sfbfe_host.send(OP_DUAL_OUT, 8);
    chk("rx after reset", n, rxCnt);
    u_sfbfe_host.desel();
  endtask : t_power

  // Main sequence, inputs change at falling edges only
  initial begin
    rst = 1'b1;
    qeBit = 1'b0;
    wip = 1'b0;
    txByte = 8'hA5;
    clkEn = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    t_armed();
    t_dual();
    t_quad();
    t_wide();
    t_pause();
    t_power();
    reportAndStop();
  end
endmodule : serial_flash_bus_front_end_bench
